// >>> rtl/ecl_loader.sv
// Function
// - after power-on reset or bus reset, read the memory to test presence and validity
// - valid contents configure the device; otherwise built-in defaults apply
// - default configuration puts both channels in asynchronous serial port mode
// - data line high where acknowledge is expected means bad command or no memory
// - memory is organised as 16-bit words, each read as one value
// - in reset, select, clock and data pins are released to high impedance
// - when the controller releases reset, the device loads its configuration
// - FIFO and isolated serial modes only when stored contents select them
// - select and clock drive the memory; commands go out on the data line
`timescale 1ns/100ps
module ecl_loader
  import ecl_pkg::*;
#(
  parameter int ADDR_W = 6,
  parameter int NUM_WORDS = 64
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic link_clk_in,
  input wire logic bus_reset_in,
  output logic cfg_mem_select_out,
  output logic cfg_mem_select_oe_out,
  output logic cfg_mem_clock_out,
  output logic cfg_mem_clock_oe_out,
  input wire logic cfg_mem_data_io_in,
  output logic cfg_mem_data_io_out,
  output logic cfg_mem_data_io_oe_out,
  output logic load_done_out,
  output logic mem_present_out,
  output logic cfg_valid_out,
  output ecl_mode_type [NUM_CHAN-1:0] chan_mode_out,
  input wire logic [ADDR_W-1:0] cfg_rd_addr_in,
  output logic [WORD_W-1:0] cfg_rd_data_out
);

  localparam int CMD_W = PREFIX_W + ADDR_W;
  localparam int CNT_W = $clog2(CMD_W + WORD_W);
  localparam logic [CNT_W-1:0] CMD_LAST = CNT_W'(CMD_W - 1);
  localparam logic [CNT_W-1:0] DATA_LAST = CNT_W'(WORD_W - 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_CYC - 1);
  localparam logic [ADDR_W-1:0] IDX_LAST = ADDR_W'(NUM_WORDS - 1);
  localparam logic [ADDR_W:0] CNT_FULL = (ADDR_W + 1)'(NUM_WORDS);
  localparam logic [ADDR_W:0] CNT_MODE = (ADDR_W + 1)'(MODE_WORD_IDX);

  typedef struct packed {
    ecl_link_state_type st;
    logic [DIV_W-1:0] div;
    logic [CNT_W-1:0] bits;
    logic [CMD_W-1:0] sh;
    logic [WORD_W-1:0] rx;
    logic [ADDR_W-1:0] idx;
    logic seen;
    logic word_tgl;
    ecl_xfer_type xf;
    ecl_pins_type pins;
  } ecl_link_type;

  typedef struct packed {
    ecl_core_state_type st;
    logic start_tgl;
    logic ack_tgl;
    logic [ADDR_W:0] cnt;
    logic [WORD_W-1:0] sum;
    logic [WORD_W-1:0] mode_word;
    logic present;
    logic valid;
    ecl_mode_type [NUM_CHAN-1:0] modes;
  } ecl_core_type;

  ecl_link_type l_reg;
  ecl_link_type l_next;
  ecl_core_type c_reg;
  ecl_core_type c_next;

  logic link_run;
  logic link_rst;
  logic start_s;
  logic ack_s;
  logic din_s;
  logic word_s;
  logic tick;
  logic pending;
  logic wr_en;
  logic [WORD_W-1:0] sum_all;
  ecl_mode_type [NUM_CHAN-1:0] dec_modes;

  // reset for the link domain: asserts with reset_in, releases on link_clk_in
  ecl_sync #(.W(1)) u_link_rst (
    .clk_in(link_clk_in),
    .reset_in(reset_in),
    .d_in(1'b1),
    .q_out(link_run)
  );
  assign link_rst = ~link_run;

  ecl_sync #(.W(3)) u_to_link (
    .clk_in(link_clk_in),
    .reset_in(link_rst),
    .d_in({c_reg.start_tgl, c_reg.ack_tgl, cfg_mem_data_io_in}),
    .q_out({start_s, ack_s, din_s})
  );

  ecl_sync #(.W(1)) u_to_core (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .d_in(l_reg.word_tgl),
    .q_out(word_s)
  );

  // link side: bit engine clocked by link_clk_in, divided to the memory rate
  assign tick = (l_reg.div == DIV_LAST);
  assign pending = (l_reg.word_tgl != ack_s);

  always_comb begin
    l_next = l_reg;
    l_next.div = tick ? '0 : l_reg.div + DIV_W'(1);
    l_next.pins.sel_oe = 1'b1;
    l_next.pins.clk_oe = 1'b1;
    case (l_reg.st)
      ECL_L_IDLE: begin
        l_next.pins.sel = 1'b0;
        l_next.pins.clk = 1'b0;
      end
      ECL_L_GAP: begin
        if (tick) begin
          l_next.pins.sel = 1'b1;
          l_next.sh = {RD_PREFIX, l_reg.idx};
          l_next.pins.dat = RD_PREFIX[PREFIX_W-1];
          l_next.pins.dat_oe = 1'b1;
          l_next.bits = '0;
          l_next.st = ECL_L_CMD;
        end
      end
      ECL_L_CMD: begin
        if (tick) begin
          if (!l_reg.pins.clk) begin
            l_next.pins.clk = 1'b1;
          end else begin
            l_next.pins.clk = 1'b0;
            if (l_reg.bits == CMD_LAST) begin
              // hand the data line to the memory for its reply
              l_next.pins.dat_oe = 1'b0;
              l_next.st = ECL_L_ACK;
            end else begin
              l_next.sh = l_reg.sh << 1;
              l_next.pins.dat = l_reg.sh[CMD_W-2];
              l_next.bits = l_reg.bits + CNT_W'(1);
            end
          end
        end
      end
      ECL_L_ACK: begin
        if (tick) begin
          if (din_s) begin
            // pulled high: no memory or command not taken
            l_next.pins.sel = 1'b0;
            l_next.xf.fail = 1'b1;
            l_next.xf.last = 1'b1;
            l_next.word_tgl = ~l_reg.word_tgl;
            l_next.st = ECL_L_HAND;
          end else begin
            l_next.pins.clk = 1'b1;
            l_next.bits = '0;
            l_next.st = ECL_L_DATA;
          end
        end
      end
      ECL_L_DATA: begin
        if (tick) begin
          if (!l_reg.pins.clk) begin
            l_next.pins.clk = 1'b1;
          end else begin
            l_next.pins.clk = 1'b0;
            l_next.rx = {l_reg.rx[WORD_W-2:0], din_s};
            l_next.bits = l_reg.bits + CNT_W'(1);
            if (l_reg.bits == DATA_LAST) begin
              l_next.pins.sel = 1'b0;
              l_next.xf.data = {l_reg.rx[WORD_W-2:0], din_s};
              l_next.xf.last = 1'b0;
              l_next.word_tgl = ~l_reg.word_tgl;
              l_next.st = ECL_L_HAND;
            end
          end
        end
      end
      ECL_L_HAND: begin
        if (!pending) begin
          if (l_reg.xf.last) begin
            l_next.st = ECL_L_IDLE;
          end else if (l_reg.idx == IDX_LAST) begin
            l_next.xf.last = 1'b1;
            l_next.word_tgl = ~l_reg.word_tgl;
          end else begin
            l_next.idx = l_reg.idx + ADDR_W'(1);
            l_next.div = '0;
            l_next.st = ECL_L_GAP;
          end
        end
      end
      default: begin
        l_next.st = ECL_L_IDLE;
      end
    endcase
    // a new run waits until select is low, so no clock half or turnaround is cut short
    if (start_s != l_reg.seen && !pending && !l_reg.pins.sel) begin
      l_next.seen = start_s;
      l_next.xf.tag = start_s;
      l_next.xf.fail = 1'b0;
      l_next.xf.last = 1'b0;
      l_next.idx = '0;
      l_next.div = '0;
      l_next.pins.sel = 1'b0;
      l_next.pins.clk = 1'b0;
      l_next.pins.dat_oe = 1'b0;
      l_next.st = ECL_L_GAP;
    end
  end

  // reset releases every pin so a sharing controller can use the memory
  always_ff @(posedge link_clk_in or posedge link_rst) begin
    if (link_rst) begin
      l_reg <= '0;
    end else begin
      l_reg <= l_next;
    end
  end

  assign cfg_mem_select_out = l_reg.pins.sel;
  assign cfg_mem_select_oe_out = l_reg.pins.sel_oe;
  assign cfg_mem_clock_out = l_reg.pins.clk;
  assign cfg_mem_clock_oe_out = l_reg.pins.clk_oe;
  assign cfg_mem_data_io_out = l_reg.pins.dat;
  assign cfg_mem_data_io_oe_out = l_reg.pins.dat_oe;

  // core side: collects words, checks them and applies the port modes
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
      logic [MODE_FIELD_W-1:0] field;
      assign field = c_reg.mode_word[ch*MODE_FIELD_W +: MODE_FIELD_W];
      always_comb begin
        if (field == ECL_MODE_FIFO) begin
          dec_modes[ch] = ECL_MODE_FIFO;
        end else if (field == ECL_MODE_OPTO) begin
          dec_modes[ch] = ECL_MODE_OPTO;
        end else begin
          dec_modes[ch] = ECL_MODE_UART;
        end
      end
    end
  endgenerate

  assign sum_all = c_reg.sum;

  // xf is read only after its toggle has crossed, so it is stable here
  always_comb begin
    c_next = c_reg;
    wr_en = 1'b0;
    case (c_reg.st)
      ECL_C_START: begin
        c_next.start_tgl = ~c_reg.start_tgl;
        c_next.cnt = '0;
        c_next.sum = '0;
        c_next.present = 1'b0;
        c_next.valid = 1'b0;
        c_next.modes = {NUM_CHAN{ECL_MODE_UART}};
        c_next.st = ECL_C_LOAD;
      end
      ECL_C_LOAD: begin
        if (word_s != c_reg.ack_tgl) begin
          c_next.ack_tgl = word_s;
          if (l_reg.xf.tag == c_reg.start_tgl) begin
            if (l_reg.xf.last) begin
              c_next.present = ~l_reg.xf.fail;
              c_next.valid = ~l_reg.xf.fail && c_reg.cnt == CNT_FULL
                && sum_all == CHK_VALUE;
              if (c_next.valid) begin
                c_next.modes = dec_modes;
              end else begin
                c_next.modes = {NUM_CHAN{ECL_MODE_UART}};
              end
              c_next.st = ECL_C_DONE;
            end else if (c_reg.cnt != CNT_FULL) begin
              wr_en = 1'b1;
              c_next.sum = c_reg.sum + l_reg.xf.data;
              if (c_reg.cnt == CNT_MODE) begin
                c_next.mode_word = l_reg.xf.data;
              end
              c_next.cnt = c_reg.cnt + (ADDR_W + 1)'(1);
            end
          end
        end
      end
      default: begin
      end
    endcase
    if (bus_reset_in) begin
      c_next.st = ECL_C_START;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      c_reg <= '0;
    end else begin
      c_reg <= c_next;
    end
  end

  assign load_done_out = (c_reg.st == ECL_C_DONE);
  assign mem_present_out = c_reg.present;
  assign cfg_valid_out = c_reg.valid;
  assign chan_mode_out = c_reg.modes;

  ecl_store #(.DEPTH(NUM_WORDS), .AW(ADDR_W), .DW(WORD_W)) u_store (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .wr_en_in(wr_en),
    .wr_addr_in(c_reg.cnt[ADDR_W-1:0]),
    .wr_data_in(l_reg.xf.data),
    .rd_addr_in(cfg_rd_addr_in),
    .rd_data_out(cfg_rd_data_out)
  );

endmodule

// >>> rtl/ecl_pkg.sv
package ecl_pkg;

  // serial memory clock: 1 Mb/s, so each half period lasts at least 500 ns
  localparam int LINK_PERIOD_PS = 6000;
  localparam int MEM_HALF_NS = 500;
  localparam int HALF_CYC = (MEM_HALF_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam int DIV_W = 8;

  localparam int WORD_W = 16;
  // start bit 1 followed by read opcode 2'b10
  localparam int PREFIX_W = 3;
  localparam logic [2:0] RD_PREFIX = 3'h6;

  // stored 16-bit sum over all words must equal this value
  localparam logic [15:0] CHK_VALUE = 16'ha55a;
  localparam int MODE_WORD_IDX = 0;
  localparam int MODE_FIELD_W = 2;
  localparam int NUM_CHAN = 2;

  typedef enum logic [1:0] {
    ECL_MODE_UART = 2'b00,
    ECL_MODE_FIFO = 2'b01,
    ECL_MODE_OPTO = 2'b10
  } ecl_mode_type;

  typedef enum logic [2:0] {
    ECL_L_IDLE = 3'b000,
    ECL_L_GAP = 3'b001,
    ECL_L_CMD = 3'b010,
    ECL_L_ACK = 3'b011,
    ECL_L_DATA = 3'b100,
    ECL_L_HAND = 3'b101
  } ecl_link_state_type;

  typedef enum logic [1:0] {
    ECL_C_START = 2'b00,
    ECL_C_LOAD = 2'b01,
    ECL_C_DONE = 2'b10
  } ecl_core_state_type;

  typedef struct packed {
    logic sel;
    logic sel_oe;
    logic clk;
    logic clk_oe;
    logic dat;
    logic dat_oe;
  } ecl_pins_type;

  // held stable by the link side from its toggle until the core acknowledges
  typedef struct packed {
    logic tag;
    logic last;
    logic fail;
    logic [WORD_W-1:0] data;
  } ecl_xfer_type;

endpackage

// >>> rtl/ecl_sync.sv
`timescale 1ns/100ps
module ecl_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } ecl_sync_state_type;

  ecl_sync_state_type s_reg;
  ecl_sync_state_type s_next;

  // the first stage feeds only the second stage
  always_comb begin
    s_next.meta = d_in;
    s_next.q = s_reg.meta;
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q_out = s_reg.q;

endmodule

// >>> rtl/ecl_store.sv
`timescale 1ns/100ps
module ecl_store #(
  parameter int DEPTH = 64,
  parameter int AW = 6,
  parameter int DW = 16
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [DW-1:0] wr_data_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic [DW-1:0] rd_data_out
);

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [DW-1:0] rd;
  } ecl_store_state_type;

  ecl_store_state_type s_reg;
  ecl_store_state_type s_next;

  always_comb begin
    s_next = s_reg;
    if (wr_en_in) begin
      s_next.mem[wr_addr_in] = wr_data_in;
    end
    s_next.rd = s_reg.mem[rd_addr_in];
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rd_data_out = s_reg.rd;

endmodule

// >>> tb/ecl_loader_chk.sv
`timescale 1ns/100ps
module ecl_loader_chk
  import ecl_pkg::*;
(
  input wire logic reset_in,
  input wire logic clk_in,
  input wire logic link_clk_in,
  input wire logic cfg_mem_select_out,
  input wire logic cfg_mem_clock_out,
  input wire logic cfg_mem_data_io_out,
  input wire logic cfg_mem_data_io_oe_out,
  input wire logic load_done_out,
  input wire logic mem_present_out,
  input wire logic cfg_valid_out,
  input wire ecl_mode_type [NUM_CHAN-1:0] chan_mode_out
);
  localparam int HALF_M1 = HALF_CYC - 1;
  logic clk_prev_reg;
  logic [DIV_W-1:0] half_cnt_reg;

  // pin checks run on the link clock, load results on the core clock

  always_ff @(posedge link_clk_in or posedge reset_in) begin
    if (reset_in) begin
      clk_prev_reg <= 1'b0;
      half_cnt_reg <= '0;
    end else begin
      clk_prev_reg <= cfg_mem_clock_out;
      half_cnt_reg <= (cfg_mem_clock_out != clk_prev_reg) ? '0 : half_cnt_reg + 1'b1;
    end
  end

  sequence s_start_bit;
    cfg_mem_data_io_oe_out && cfg_mem_data_io_out && !cfg_mem_clock_out;
  endsequence
  sequence s_ack_wait;
    (cfg_mem_select_out && !cfg_mem_clock_out && !cfg_mem_data_io_oe_out) [*8];
  endsequence

  AST_DOE_IN_FRAME: assert property (@(posedge link_clk_in) disable iff (reset_in)
    cfg_mem_data_io_oe_out |-> cfg_mem_select_out) else $error("data driven while deselected");
  AST_CLK_IN_FRAME: assert property (@(posedge link_clk_in) disable iff (reset_in)
    !cfg_mem_select_out |-> !cfg_mem_clock_out) else $error("clock high while deselected");
  AST_HIGH_HALF: assert property (@(posedge link_clk_in) disable iff (reset_in)
    $fell(cfg_mem_clock_out) |-> half_cnt_reg == HALF_M1)
    else $error("clock high half has wrong length");
  AST_BIT_STABLE: assert property (@(posedge link_clk_in) disable iff (reset_in)
    cfg_mem_clock_out && $past(cfg_mem_clock_out) && cfg_mem_data_io_oe_out
    |-> $stable(cfg_mem_data_io_out)) else $error("command bit moved while clock high");
  AST_START_BIT: assert property (@(posedge link_clk_in) disable iff (reset_in)
    $rose(cfg_mem_select_out) |-> s_start_bit) else $error("access does not open with start bit");
  AST_ACK_TURN: assert property (@(posedge link_clk_in) disable iff (reset_in)
    $fell(cfg_mem_data_io_oe_out) |-> s_ack_wait) else $error("line not released for acknowledge");
  AST_NO_MEM_NO_CFG: assert property (@(posedge clk_in) disable iff (reset_in)
    load_done_out && !mem_present_out |-> !cfg_valid_out) else $error("valid without memory");
  AST_DEFAULT_MODES: assert property (@(posedge clk_in) disable iff (reset_in)
    $rose(load_done_out) && !cfg_valid_out |-> chan_mode_out == '0)
    else $error("defaults not both serial");
endmodule

bind ecl_loader ecl_loader_chk chk_u (
  .reset_in, .clk_in, .link_clk_in, .cfg_mem_select_out, .cfg_mem_clock_out, .cfg_mem_data_io_out,
  .cfg_mem_data_io_oe_out, .load_done_out, .mem_present_out, .cfg_valid_out, .chan_mode_out
);

// >>> tb/ecl_mem_model.sv
`timescale 1ns/100ps
module ecl_mem_model
  import ecl_pkg::*;
#(
  parameter int AW = 1
) (
  input wire logic cs_in,
  input wire logic memory_clock_in,
  input wire logic di_in,
  input wire logic present_in,
  input wire logic [2**AW-1:0][WORD_W-1:0] image_in,
  output logic do_out,
  output logic do_oe_out
);
  int cnt = 0;
  logic [AW+2:0] cmd = '0;

  initial begin
    do_out = 1'b1;
    do_oe_out = 1'b0;
  end

  // works at any clock rate, the 1 Mb/s access included
  always @(posedge memory_clock_in or negedge cs_in) begin
    if (!cs_in) begin
      cnt = 0;
      do_oe_out = 1'b0;
    end else begin
      cnt = cnt + 1;
      if (cnt <= AW + 3) begin
        cmd = {cmd[AW+1:0], di_in};
      end
      if (cnt == AW + 3) begin
        do_oe_out = present_in && cmd[AW+2:AW] == RD_PREFIX;
        do_out = 1'b0;
      end else if (cnt > AW + 3 && cnt <= AW + 19) begin
        do_out = image_in[cmd[AW-1:0]][AW+19-cnt];
      end else if (cnt > AW + 19) begin
        do_oe_out = 1'b0;
      end
    end
  end
endmodule

// >>> tb/testbench.sv
`timescale 1ns/100ps
module testbench
  import ecl_pkg::*;
;
  localparam int AW = 1;
  logic clk_in = 1'b0;
  logic link_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic bus_reset_in = 1'b0;
  logic [AW-1:0] cfg_rd_addr_in = '0;
  logic cfg_mem_select_out, cfg_mem_select_oe_out, cfg_mem_clock_out, cfg_mem_clock_oe_out;
  logic cfg_mem_data_io_out, cfg_mem_data_io_oe_out, load_done_out, mem_present_out;
  logic cfg_valid_out, mem_d, mem_oe;
  logic present = 1'b1;
  logic [1:0][WORD_W-1:0] image = '0;
  logic [WORD_W-1:0] cfg_rd_data_out;
  ecl_mode_type [NUM_CHAN-1:0] chan_mode_out;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  integer seed = 32'hd4a3;
  // pull-up when nobody drives; the device wins a clash
  wire cfg_mem_data_io_in = cfg_mem_data_io_oe_out ? cfg_mem_data_io_out :
    (mem_oe ? mem_d : 1'b1);

  ecl_loader #(.ADDR_W(AW), .NUM_WORDS(2)) dut_u (
    .clk_in, .reset_in, .link_clk_in, .bus_reset_in, .cfg_mem_select_out,
    .cfg_mem_select_oe_out, .cfg_mem_clock_out, .cfg_mem_clock_oe_out, .cfg_mem_data_io_in,
    .cfg_mem_data_io_out, .cfg_mem_data_io_oe_out, .load_done_out, .mem_present_out,
    .cfg_valid_out, .chan_mode_out, .cfg_rd_addr_in, .cfg_rd_data_out
  );
  ecl_mem_model #(.AW(AW)) mem_u (
    .cs_in(cfg_mem_select_out), .memory_clock_in(cfg_mem_clock_out),
    .di_in(cfg_mem_data_io_in), .present_in(present), .image_in(image),
    .do_out(mem_d), .do_oe_out(mem_oe)
  );

  always #2 clk_in = ~clk_in;
  initial begin
    #1.3;
    forever #3 link_clk_in = ~link_clk_in;
  end

  task automatic conclude();
    if (errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 90000) begin
      errors++;
      conclude();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [3:0] exp_modes(input logic [15:0] w0, input logic ok);
    logic [3:0] m;
    m = '0;
    for (int c = 0; c < 2; c++) begin
      if (ok && w0[2*c +: 2] inside {2'b01, 2'b10}) begin
        m[2*c +: 2] = w0[2*c +: 2];
      end
    end
    return m;
  endfunction

  // restarts through a bus reset, so a load still running is cut short
  task automatic load(input logic [15:0] w0, input logic [15:0] w1, input logic here);
    logic ok;
    int n;
    ok = here && (w0 + w1 == CHK_VALUE);
    image = {w1, w0};
    present = here;
    bus_reset_in = 1'b1;
    @(negedge clk_in);
    bus_reset_in = 1'b0;
    n = 0;
    repeat (2) @(negedge clk_in);
    check("done cleared", load_done_out, 16'h0);
    while (load_done_out !== 1'b1 && n < 30000) begin
      @(negedge clk_in);
      n++;
    end
    check("load finished", load_done_out, 16'h1);
    check("pins enabled", {cfg_mem_select_oe_out, cfg_mem_clock_oe_out}, 16'h3);
    check("present", mem_present_out, here);
    check("valid", cfg_valid_out, ok);
    check("modes", chan_mode_out, exp_modes(w0, ok));
    for (int a = 0; a < 2 && here; a++) begin
      cfg_rd_addr_in = a[AW-1:0];
      @(negedge clk_in);
      check("word", cfg_rd_data_out, a ? w1 : w0);
    end
  endtask

  initial begin
    logic [15:0] w;
    image = {16'h5a5a, 16'h0009};
    repeat (10) @(negedge clk_in);
    check("pins released", {cfg_mem_select_oe_out, cfg_mem_clock_oe_out,
      cfg_mem_data_io_oe_out}, 16'h0);
    check("reset modes", chan_mode_out, 16'h0);
    repeat (10) @(negedge clk_in);
    reset_in = 1'b0; // sharing controller done with the memory
    repeat (500 + ($unsigned($random(seed)) % 3000)) @(negedge clk_in);
    w = {16'($random(seed)) & 16'hfff0} | 16'h0009;
    load(w, CHK_VALUE - w, 1'b1);
    w = {16'($random(seed)) & 16'hfff0} | 16'h0003;
    load(w, CHK_VALUE - w, 1'b1);
    w = {16'($random(seed)) & 16'hfff0} | 16'h0006;
    load(w, CHK_VALUE - w, 1'b1);
    w = {16'($random(seed)) & 16'hfff0} | 16'h0009;
    load(w, CHK_VALUE - w + 16'h0001, 1'b1);
    load(w, w, 1'b0);
    conclude();
  end
endmodule
